// *** inc/clsc_pkg.sv ***
`default_nettype none
package clsc_pkg;
   // core population and word sizes
   localparam int NUM_CORES = 8;
   localparam int ID_W = 3;
   localparam int WORD_W = 32;
   // hub instruction word layout
   localparam int OP_HI = 31;
   localparam int OP_LO = 26;
   localparam logic [5:0] OP_HUB = 6'h03;
   localparam int EFF_WZ_BIT = 25;
   localparam int EFF_WC_BIT = 24;
   localparam int EFF_WR_BIT = 23;
   localparam int SRC_HI = 8;
   localparam int SRC_LO = 0;
   localparam logic [8:0] SRC_OWN_ID = 9'h001;
   localparam logic [8:0] SRC_LAUNCH = 9'h002;
   // launch descriptor layout
   localparam int DESC_PAR_HI = 31;
   localparam int DESC_PAR_LO = 18;
   localparam int DESC_CODE_HI = 17;
   localparam int DESC_CODE_LO = 4;
   localparam int DESC_NEW_BIT = 3;
   localparam int DESC_ID_HI = 2;
   localparam int DESC_ID_LO = 0;
   // started core's parameter register
   localparam int PAR_W = 16;
   localparam int PAR_FIELD_LO = 2;
   // core register file load
   localparam int REG_ADDR_W = 9;
   localparam int MEM_ADDR_W = 14;
   localparam logic [8:0] REG_FIRST = 9'h000;
   localparam logic [8:0] LOAD_LAST = 9'h1ef;
   localparam logic [8:0] SPR_LAST = 9'h1ff;
   // reset values and answers
   localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
   localparam logic [2:0] NO_CORE_ID = 3'h7;
   // hub timing: answer appears DONE_STAGES-1 cycles after the slot service edge
   localparam int DONE_STAGES = 8;
   localparam int MIN_HUB_CLOCKS = 8;
   localparam int MAX_HUB_CLOCKS = 23;
   typedef enum {
      CLSC_LD_IDLE,
      CLSC_LD_COPY,
      CLSC_LD_START
   } clsc_ld_state_t;
endpackage
`default_nettype wire

// *** design/clsc_hub.sv ***
// Operation
// (RQ1) one shared 32-bit system time counter, plus one every clock
// (RQ2) counter value is presented read-only to every core as a source
// (RQ3) destination writes at counter address hit a per-core shadow register
// (RQ4) own-ID query returns requester ID 0-7, written unless no-write effect given; code writes it only with the write-result bit
// (RQ5) own-ID query sets zero flag only when returned ID is zero
// (RQ6) every hub operation answers 8 to 23 clocks after being taken; a launch held while the loader is busy takes longer
// (RQ7) hub ops use major opcode 000011; source value 1 means own-ID query
// (RQ8) source value 2 means core launch
// (RQ9) descriptor: parameter 31:18, code 17:4, next-free bit 3, core 2:0
// (RQ10) descriptor bits 31:18 become bits 15:2 of started core's parameter
// (RQ11) load registers 000..1EF from code, zero the specials, start at 000
// (RQ12) next-free launch starts lowest inactive core and returns its ID
// (RQ13) explicit launch always starts or restarts the named core, returns it
// (RQ14) next-free launch with no free core sets carry and returns 7
// (RQ15) launch sets zero flag only when returned ID equals 0
// (RQ16) launch writes destination only with the write-result effect
// (RQ17) hub is granted to one core per slot, so selections never collide
`timescale 1ns/10ps
`default_nettype none
module clsc_hub (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // per-core hub requests
   input wire logic [7:0] i_hub_req,
   input wire logic [7:0][31:0] i_hub_instr,
   input wire logic [7:0][31:0] i_hub_dest,
   output logic [7:0] o_hub_busy,
   // per-core hub answers
   output logic [7:0] o_hub_done,
   output logic [7:0][31:0] o_hub_result,
   output logic [7:0] o_hub_result_we,
   output logic [7:0] o_hub_z,
   output logic [7:0] o_hub_z_we,
   output logic [7:0] o_hub_c,
   output logic [7:0] o_hub_c_we,
   // system time counter and its shadows
   output logic [31:0] o_system_time_counter,
   input wire logic [7:0] i_shadow_we,
   input wire logic [7:0][31:0] i_shadow_wdata,
   output logic [7:0][31:0] o_shadow_rdata,
   // core run control
   input wire logic [7:0] i_core_stopped,
   output logic [7:0] o_core_active,
   output logic [7:0] o_core_hold,
   output logic [7:0] o_core_start,
   output logic [15:0] o_launch_parameter_register,
   // code fetch from main memory, data one cycle after address
   output logic o_mem_rd_en,
   output logic [13:0] o_mem_addr,
   input wire logic [31:0] i_mem_rdata,
   // core register file load
   output logic o_core_wr_en,
   output logic [2:0] o_core_wr_sel,
   output logic [8:0] o_core_wr_addr,
   output logic [31:0] o_core_wr_data
);

   logic [31:0] counter_q;
   logic [7:0][31:0] shadow_q;
   logic [2:0] slot_q;
   logic phase_q;
   logic [7:0] pending_q;
   logic [7:0][31:0] instr_q;
   logic [7:0][31:0] dest_q;
   logic [7:0][clsc_pkg::DONE_STAGES-1:0] stage_q;
   logic [7:0][31:0] result_q;
   logic [7:0] result_we_q;
   logic [7:0] z_q;
   logic [7:0] z_we_q;
   logic [7:0] c_q;
   logic [7:0] c_we_q;
   logic [7:0] active_q;
   logic [7:0] hold_q;
   logic [7:0] start_q;
   logic [15:0] par_q;
   clsc_pkg::clsc_ld_state_t ld_state_q;
   logic [2:0] ld_core_q;
   logic [13:0] ld_code_q;
   logic [15:0] ld_par_q;
   logic [8:0] ld_idx_q;
   logic wr_en_q;
   logic wr_zero_q;
   logic [8:0] wr_addr_q;

   // decode of the core that owns the current slot
   logic [31:0] sv_instr;
   logic [31:0] sv_dest;
   logic sv_is_hub;
   logic sv_is_id;
   logic sv_is_launch;
   logic sv_fire;
   logic ld_idle;
   logic [2:0] free_id;
   logic free_found;
   logic [2:0] launch_id;
   logic launch_go;
   logic launch_none;
   logic [2:0] ret_id;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         counter_q <= clsc_pkg::COUNTER_RESET;
      end else begin
         counter_q <= counter_q + 32'h0000_0001; // [RQ1]
      end
   end
   assign o_system_time_counter = counter_q; // [RQ2]

   // writes aimed at the counter address never reach the counter itself
   always_ff @(posedge i_clk_sys) begin
      for (int c = 0; c < clsc_pkg::NUM_CORES; c++) begin
         if (i_sys_rst) begin
            shadow_q[c] <= 32'h0000_0000;
         end else if (i_shadow_we[c]) begin
            shadow_q[c] <= i_shadow_wdata[c]; // [RQ3]
         end
      end
   end
   assign o_shadow_rdata = shadow_q;

   // round-robin slot: two clocks per core, sixteen per turn
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         phase_q <= 1'b0;
         slot_q <= 3'h0;
      end else begin
         phase_q <= ~phase_q;
         if (phase_q) begin
            slot_q <= slot_q + 3'h1; // [RQ17]
         end
      end
   end

   always_comb begin
      for (int c = 0; c < clsc_pkg::NUM_CORES; c++) begin
         o_hub_busy[c] = pending_q[c] | (|stage_q[c]);
      end
   end

   assign sv_instr = instr_q[slot_q];
   assign sv_dest = dest_q[slot_q];
   assign sv_is_hub = sv_instr[clsc_pkg::OP_HI:clsc_pkg::OP_LO] == clsc_pkg::OP_HUB; // [RQ7]
   assign sv_is_id = sv_is_hub &&
      (sv_instr[clsc_pkg::SRC_HI:clsc_pkg::SRC_LO] == clsc_pkg::SRC_OWN_ID); // [RQ7]
   assign sv_is_launch = sv_is_hub &&
      (sv_instr[clsc_pkg::SRC_HI:clsc_pkg::SRC_LO] == clsc_pkg::SRC_LAUNCH); // [RQ8]
   assign ld_idle = ld_state_q == clsc_pkg::CLSC_LD_IDLE;
   // a launch is retried each turn until the loader has finished its current load
   assign sv_fire = pending_q[slot_q] & ~phase_q & (~sv_is_launch | ld_idle); // [RQ17]

   always_comb begin
      free_found = 1'b0;
      free_id = clsc_pkg::NO_CORE_ID;
      for (int c = clsc_pkg::NUM_CORES - 1; c >= 0; c--) begin
         if (!active_q[c]) begin
            free_found = 1'b1;
            free_id = 3'(c); // [RQ12]
         end
      end
   end

   always_comb begin
      launch_go = 1'b1;
      launch_none = 1'b0;
      if (sv_dest[clsc_pkg::DESC_NEW_BIT]) begin // [RQ9]
         launch_id = free_id; // [RQ12]
         if (!free_found) begin
            launch_go = 1'b0;
            launch_none = 1'b1;
            launch_id = clsc_pkg::NO_CORE_ID; // [RQ14]
         end
      end else begin
         launch_id = sv_dest[clsc_pkg::DESC_ID_HI:clsc_pkg::DESC_ID_LO]; // [RQ13]
      end
   end
   assign ret_id = sv_is_launch ? launch_id : slot_q; // [RQ4]

   always_ff @(posedge i_clk_sys) begin
      for (int c = 0; c < clsc_pkg::NUM_CORES; c++) begin
         if (i_sys_rst) begin
            pending_q[c] <= 1'b0;
            instr_q[c] <= 32'h0000_0000;
            dest_q[c] <= 32'h0000_0000;
         end else if (i_hub_req[c] && !o_hub_busy[c]) begin
            pending_q[c] <= 1'b1;
            instr_q[c] <= i_hub_instr[c];
            dest_q[c] <= i_hub_dest[c];
         end else if (sv_fire && (slot_q == 3'(c))) begin
            pending_q[c] <= 1'b0;
         end
      end
   end

   // service edge plus eight stages gives 8..23 clocks from request, longer for a launch held while the loader is busy
   always_ff @(posedge i_clk_sys) begin
      for (int c = 0; c < clsc_pkg::NUM_CORES; c++) begin
         if (i_sys_rst) begin
            stage_q[c] <= '0;
         end else begin
            stage_q[c] <= {stage_q[c][clsc_pkg::DONE_STAGES-2:0],
               sv_fire && (slot_q == 3'(c))}; // [RQ6]
         end
      end
   end

   always_comb begin
      for (int c = 0; c < clsc_pkg::NUM_CORES; c++) begin
         o_hub_done[c] = stage_q[c][clsc_pkg::DONE_STAGES-1];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      for (int c = 0; c < clsc_pkg::NUM_CORES; c++) begin
         if (i_sys_rst) begin
            result_q[c] <= 32'h0000_0000;
            result_we_q[c] <= 1'b0;
            z_q[c] <= 1'b0;
            z_we_q[c] <= 1'b0;
            c_q[c] <= 1'b0;
            c_we_q[c] <= 1'b0;
         end else if (sv_fire && (slot_q == 3'(c))) begin
            result_q[c] <= {29'h0, ret_id}; // [RQ4]
            // own-ID and launch both write only if told to by the write-result bit
            result_we_q[c] <= (sv_is_id | sv_is_launch) &
               sv_instr[clsc_pkg::EFF_WR_BIT]; // [RQ4] [RQ16]
            z_q[c] <= ret_id == 3'h0; // [RQ5] [RQ15]
            z_we_q[c] <= (sv_is_id | sv_is_launch) & sv_instr[clsc_pkg::EFF_WZ_BIT];
            c_q[c] <= sv_is_launch & launch_none; // [RQ14]
            c_we_q[c] <= (sv_is_id | sv_is_launch) & sv_instr[clsc_pkg::EFF_WC_BIT];
         end
      end
   end
   assign o_hub_result = result_q;
   assign o_hub_result_we = result_we_q;
   assign o_hub_z = z_q;
   assign o_hub_z_we = z_we_q;
   assign o_hub_c = c_q;
   assign o_hub_c_we = c_we_q;

   // launch marks the core busy at once so the next slot sees it taken
   always_ff @(posedge i_clk_sys) begin
      for (int c = 0; c < clsc_pkg::NUM_CORES; c++) begin
         if (i_sys_rst) begin
            active_q[c] <= 1'b0;
         end else if (sv_fire && sv_is_launch && launch_go && (launch_id == 3'(c))) begin
            active_q[c] <= 1'b1; // [RQ17]
         end else if (i_core_stopped[c]) begin
            active_q[c] <= 1'b0;
         end
      end
   end
   assign o_core_active = active_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ld_state_q <= clsc_pkg::CLSC_LD_IDLE;
         ld_core_q <= 3'h0;
         ld_code_q <= '0;
         ld_par_q <= 16'h0000;
         ld_idx_q <= clsc_pkg::REG_FIRST;
      end else begin
         case (ld_state_q)
            clsc_pkg::CLSC_LD_IDLE: begin
               if (sv_fire && sv_is_launch && launch_go) begin
                  ld_core_q <= launch_id; // [RQ12] [RQ13]
                  ld_code_q <= sv_dest[clsc_pkg::DESC_CODE_HI:clsc_pkg::DESC_CODE_LO]; // [RQ9]
                  ld_par_q <= {sv_dest[clsc_pkg::DESC_PAR_HI:clsc_pkg::DESC_PAR_LO],
                     2'b00}; // [RQ10]
                  ld_idx_q <= clsc_pkg::REG_FIRST;
                  ld_state_q <= clsc_pkg::CLSC_LD_COPY;
               end
            end
            clsc_pkg::CLSC_LD_COPY: begin
               ld_idx_q <= ld_idx_q + 9'h001; // [RQ11]
               if (ld_idx_q == clsc_pkg::SPR_LAST) begin
                  ld_state_q <= clsc_pkg::CLSC_LD_START;
               end
            end
            clsc_pkg::CLSC_LD_START: begin
               ld_state_q <= clsc_pkg::CLSC_LD_IDLE;
            end
            default: begin
               ld_state_q <= clsc_pkg::CLSC_LD_IDLE;
            end
         endcase
      end
   end

   assign o_mem_rd_en = (ld_state_q == clsc_pkg::CLSC_LD_COPY) &&
      (ld_idx_q <= clsc_pkg::LOAD_LAST); // [RQ11]
   // index widened to the long-address width before the add
   function automatic logic [13:0] mem_idx_ext(input logic [8:0] idx);
      mem_idx_ext = {5'h00, idx};
   endfunction
   assign o_mem_addr = ld_code_q + mem_idx_ext(ld_idx_q);

   // write stage trails the fetch by one clock to meet the memory latency
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         wr_en_q <= 1'b0;
         wr_zero_q <= 1'b0;
         wr_addr_q <= clsc_pkg::REG_FIRST;
      end else begin
         wr_en_q <= ld_state_q == clsc_pkg::CLSC_LD_COPY;
         wr_zero_q <= ld_idx_q > clsc_pkg::LOAD_LAST; // [RQ11]
         wr_addr_q <= ld_idx_q;
      end
   end
   assign o_core_wr_en = wr_en_q;
   assign o_core_wr_sel = ld_core_q;
   assign o_core_wr_addr = wr_addr_q;
   assign o_core_wr_data = wr_zero_q ? 32'h0000_0000 : i_mem_rdata; // [RQ11]

   // target core is held in reset while its registers are rewritten
   always_ff @(posedge i_clk_sys) begin
      for (int c = 0; c < clsc_pkg::NUM_CORES; c++) begin
         if (i_sys_rst) begin
            hold_q[c] <= 1'b0;
            start_q[c] <= 1'b0;
         end else begin
            if (ld_idle && sv_fire && sv_is_launch && launch_go && (launch_id == 3'(c))) begin
               hold_q[c] <= 1'b1; // [RQ13]
            end else if ((ld_state_q == clsc_pkg::CLSC_LD_START) && (ld_core_q == 3'(c))) begin
               hold_q[c] <= 1'b0;
            end
            start_q[c] <= (ld_state_q == clsc_pkg::CLSC_LD_START) &&
               (ld_core_q == 3'(c)); // [RQ11]
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         par_q <= 16'h0000;
      end else if (ld_state_q == clsc_pkg::CLSC_LD_START) begin
         par_q <= ld_par_q; // [RQ10]
      end
   end
   assign o_core_hold = hold_q;
   assign o_core_start = start_q;
   assign o_launch_parameter_register = par_q;

endmodule
`default_nettype wire

// *** verification/clsc_hub_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module clsc_hub_properties (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // hub requests and answers
   input wire logic [7:0] i_hub_req,
   input wire logic [7:0] o_hub_busy,
   input wire logic [7:0] o_hub_done,
   input wire logic [7:0][31:0] o_hub_result,
   input wire logic [7:0] o_hub_z,
   input wire logic [7:0] o_hub_z_we,
   input wire logic [7:0] o_hub_c,
   input wire logic [7:0] o_hub_c_we,
   // counter and shadows
   input wire logic [31:0] o_system_time_counter,
   input wire logic [7:0] i_shadow_we,
   input wire logic [7:0][31:0] i_shadow_wdata,
   input wire logic [7:0][31:0] o_shadow_rdata,
   // core start and load
   input wire logic [7:0] o_core_active,
   input wire logic [7:0] o_core_hold,
   input wire logic [7:0] o_core_start,
   input wire logic o_core_wr_en,
   input wire logic [8:0] o_core_wr_addr,
   input wire logic [31:0] o_core_wr_data
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   a_counter_step: assert property (
      !$past(i_sys_rst) |-> o_system_time_counter == $past(o_system_time_counter) + 32'h1)
      else $error("counter did not step by one");
   for (genvar c = 0; c < 8; c++) begin : g_core
      a_hub_latency: assert property (
         i_hub_req[c] && !o_hub_busy[c] |-> ##1 !o_hub_done[c] [*7] ##[1:17] o_hub_done[c])
         else $error("hub answer outside its window");
      a_shadow_write: assert property (
         i_shadow_we[c] |=> o_shadow_rdata[c] == $past(i_shadow_wdata[c]))
         else $error("shadow write lost");
      a_zero_flag: assert property (
         o_hub_done[c] && o_hub_z_we[c] |-> o_hub_z[c] == (o_hub_result[c][2:0] == 3'h0))
         else $error("zero flag disagrees with id");
      a_carry_seven: assert property (
         o_hub_done[c] && o_hub_c_we[c] && o_hub_c[c] |-> o_hub_result[c] == 32'h7)
         else $error("no free core must answer seven");
      a_start_active: assert property (
         o_core_start[c] |-> o_core_active[c])
         else $error("started core not active");
   end
   // two loads at once would let two launches pick the same core
   a_single_load: assert property (
      $onehot0(o_core_hold) && $onehot0(o_core_start))
      else $error("more than one core loading");
   a_start_pulse: assert property (
      o_core_start != 8'h0 |=> o_core_start == 8'h0)
      else $error("start longer than one cycle");
   a_load_order: assert property (
      o_core_wr_en && o_core_wr_addr != 9'h1ff |=>
         o_core_wr_en && o_core_wr_addr == $past(o_core_wr_addr) + 9'h1)
      else $error("register load out of order");
   a_spr_zero: assert property (
      o_core_wr_en && o_core_wr_addr > 9'h1ef |-> o_core_wr_data == 32'h0)
      else $error("special register not cleared");
endmodule
`default_nettype wire

// *** verification/clsc_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module clsc_mem_model (
   // clock
   input wire logic i_clk_sys,
   // code fetch, data one cycle after address
   input wire logic i_rd_en,
   input wire logic [13:0] i_addr,
   output logic [31:0] o_rdata
);
   // idle cycles flip the word, so after an odd number of them a stale fetch cannot pass for a fresh one
   always_ff @(posedge i_clk_sys) begin
      if (i_rd_en) begin
         o_rdata <= {~i_addr, 4'h5, i_addr};
      end else begin
         o_rdata <= ~o_rdata;
      end
   end
endmodule
`default_nettype wire

// *** verification/clsc_hub_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module clsc_hub_bench;
   logic i_clk_sys = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] req = 8'h0, stop = 8'h0, sh_we = 8'h0, alive = 8'h0;
   logic [7:0][31:0] instr = '0, dest = '0, sh_wd = '0, res, sh_rd;
   logic [7:0] busy, done, rwe, z, zwe, c, cwe, act, hold, start;
   logic [31:0] cnt, mem_rd, wr_data, t;
   logic [15:0] par;
   logic [13:0] mem_addr, code, a;
   logic mem_en, wr_en;
   logic [2:0] wr_sel, sel;
   logic [8:0] wr_addr;
   logic [39:0] e;
   logic [39:0] exp_q[$];
   int n_fail = 0, num_checks = 0;
   clsc_hub dut_u (.i_clk_sys, .i_sys_rst, .i_hub_req(req), .i_hub_instr(instr),
      .i_hub_dest(dest), .o_hub_busy(busy), .o_hub_done(done), .o_hub_result(res),
      .o_hub_result_we(rwe), .o_hub_z(z), .o_hub_z_we(zwe), .o_hub_c(c), .o_hub_c_we(cwe),
      .o_system_time_counter(cnt), .i_shadow_we(sh_we), .i_shadow_wdata(sh_wd),
      .o_shadow_rdata(sh_rd), .i_core_stopped(stop), .o_core_active(act),
      .o_core_hold(hold), .o_core_start(start), .o_launch_parameter_register(par),
      .o_mem_rd_en(mem_en), .o_mem_addr(mem_addr), .i_mem_rdata(mem_rd),
      .o_core_wr_en(wr_en), .o_core_wr_sel(wr_sel), .o_core_wr_addr(wr_addr),
      .o_core_wr_data(wr_data));
   clsc_mem_model mem_u (.i_clk_sys, .i_rd_en(mem_en), .i_addr(mem_addr), .o_rdata(mem_rd));
   initial forever #12.5 i_clk_sys = ~i_clk_sys;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // fx is {zero update, carry update, write result}
   task automatic hub(input int k, input logic [8:0] src, input logic [31:0] d,
         input logic [2:0] fx, input logic [2:0] id, input logic cy, input logic known);
      logic [2:0] w;
      int i;
      for (i = 0; i < 40 && busy[k] === 1'b1; i++) @(negedge i_clk_sys);
      w = {known & fx[0], known & fx[2], known & fx[1]};
      exp_q.push_back({k[2:0], w[2] ? {29'h0, id} : 32'h0, w[2], w[1],
         w[1] & (id == 3'h0), w[0], w[0] & cy});
      req[k] = 1'b1;
      instr[k] = {6'h03, fx, 14'h0, src};
      dest[k] = d;
      @(negedge i_clk_sys);
      req[k] = 1'b0;
      for (i = 0; i < 40 && done[k] !== 1'b1; i++) @(negedge i_clk_sys);
      @(negedge i_clk_sys);
   endtask
   task automatic launch(input int k, input logic nf, input logic [2:0] cid);
      logic [31:0] d;
      logic [2:0] id;
      logic cy;
      int i;
      d = $urandom;
      d[3:0] = {nf, cid};
      id = cid;
      cy = nf & (&alive);
      if (nf) begin
         id = 3'h7;
         for (i = 7; i >= 0; i--) begin
            if (!alive[i]) id = i[2:0];
         end
      end
      sel = id;
      code = d[17:4];
      if (!cy) alive[id] = 1'b1;
      hub(k, 9'h002, d, 3'($urandom), id, cy, 1'b1);
      if (!cy) begin
         for (i = 0; i < 800 && start === 8'h0; i++) @(negedge i_clk_sys);
         check({start, par}, {8'h1 << id, d[31:18], 2'b00});
      end
   endtask
   always @(negedge i_clk_sys) begin
      for (int k = 0; k < 8; k++) begin
         if (done[k] === 1'b1) begin
            e = exp_q.pop_front();
            check({k[2:0], rwe[k] ? res[k] : 32'h0, rwe[k], zwe[k], zwe[k] & z[k], cwe[k],
               cwe[k] & c[k]}, e);
         end
      end
      if (wr_en === 1'b1) begin
         a = code + {5'h0, wr_addr};
         check({wr_sel, wr_data}, {sel, wr_addr > 9'h1ef ? 32'h0 : {~a, 4'h5, a}});
      end
   end
   initial begin
      #(25 * 20000);
      n_fail++;
      complete_run();
   end
   initial begin
      t = $urandom(65578);
      repeat (16) @(negedge i_clk_sys);
      i_sys_rst = 1'b0;
      @(negedge i_clk_sys);
      sh_wd[2] = $urandom;
      sh_we[2] = 1'b1;
      t = cnt;
      @(negedge i_clk_sys);
      sh_we[2] = 1'b0;
      check({sh_rd[2], cnt}, {sh_wd[2], t + 32'h1});
      for (int k = 0; k < 8; k++) begin
         hub(k, 9'h001, $urandom, 3'($urandom) & 3'h5, k[2:0], 1'b0, 1'b1);
      end
      hub(4, 9'h005, $urandom, 3'h7, 3'h0, 1'b0, 1'b0);
      launch(0, 1'b0, 3'h3);
      launch(1, 1'b0, 3'h3);
      for (int k = 0; k < 8; k++) begin
         launch(k, 1'b1, 3'($urandom));
      end
      stop[5] = 1'b1;
      alive[5] = 1'b0;
      @(negedge i_clk_sys);
      stop = 8'h0;
      launch(2, 1'b1, 3'h0);
      check({act, 32'(exp_q.size())}, {alive, 32'h0});
      complete_run();
   end
endmodule
bind clsc_hub clsc_hub_properties chk_u (.i_clk_sys, .i_sys_rst, .i_hub_req, .o_hub_busy,
   .o_hub_done, .o_hub_result, .o_hub_z, .o_hub_z_we, .o_hub_c, .o_hub_c_we,
   .o_system_time_counter, .i_shadow_we, .i_shadow_wdata, .o_shadow_rdata, .o_core_active,
   .o_core_hold, .o_core_start, .o_core_wr_en, .o_core_wr_addr, .o_core_wr_data);
`default_nettype wire
